/* File: hw/sensor_config_otp_ecc_regs.sv */
/*
 Configuration register bank with fuse memory control, checksum
 generation and single-error correction of the customer area.
 Assumes a fuse array controller that answers each load or burn
 request with a one-cycle otp_done, and an open-drain shared pin.
*/
`timescale 1ns/1ps
module sensor_config_otp_ecc_regs
   import sensor_cfg_pkg::*;
(
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   input  wire logic         rx_valid,
   input  wire logic [7:0]   rx_byte,
   input  wire logic         tx_ready,
   output logic              tx_valid,
   output logic [7:0]        tx_byte,
   output otp_req_t          otp_req,
   output cust_cfg_t         otp_burn_data,
   input  wire cust_cfg_t    otp_load_data,
   input  wire logic         otp_done,
   output logic              common_mode_select,
   output logic              cosine_ref_output_select,
   output logic              sine_ref_output_select,
   output logic              channel_sign_invert,
   output logic [4:0]        gain_code,
   output logic              diag_mode_active,
   output logic              diag_pin_o,
   output logic              diag_pin_oe
);

   typedef enum logic [1:0] {M_IDLE, M_LOAD, M_BURN} mem_state_t;

   mem_state_t  mem_q, mem_d;
   cust_cfg_t   cfg_q;
   logic        guard_q;
   logic        por_load_q;
   logic        diag_q;
   logic        otp_o_q;
   reg_wr_t     wr;
   logic [6:0]  rd_addr;
   logic [7:0]  rd_data;

   uart_frame_seq u_seq (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .rx_valid (rx_valid && !diag_q), // [R19]
      .rx_byte  (rx_byte),
      .tx_ready (tx_ready),
      .rd_data  (rd_data),
      .wr       (wr),
      .rd_addr  (rd_addr),
      .tx_valid (tx_valid),
      .tx_byte  (tx_byte)
   );

   // Hamming code over 47 positions plus overall parity bit
   function automatic logic [6:0] secded_calc(input logic [40:0] d);
      logic [6:0]  c;
      int unsigned k;
      c = '0;
      k = 0;
      for (int unsigned p = 1; p < 48; p++) begin
         if ((p & (p - 1)) != 0) begin
            for (int unsigned j = 0; j < 6; j++) begin
               if (p[j]) c[j] = c[j] ^ d[k];
            end
            k++;
         end
      end
      c[6] = (^d) ^ (^c[5:0]);
      return c;
   endfunction

   // Data bit that sits at Hamming position s, if any
   function automatic logic [40:0] flip_mask(input logic [5:0] s);
      logic [40:0] m;
      int unsigned k;
      m = '0;
      k = 0;
      for (int unsigned p = 1; p < 48; p++) begin
         if ((p & (p - 1)) != 0) begin
            if (p[5:0] == s) m[k] = 1'b1;
            k++;
         end
      end
      return m;
   endfunction

   // Write decode
   wire wr_ctrl  = wr.en && wr.addr == OFS_OTP_CONTROL;
   wire wr_out   = wr.en && wr.addr == OFS_OUTPUT_CONFIG;
   wire wr_gain  = wr.en && wr.addr == OFS_GAIN_DIAG;
   wire wr_tag0  = wr.en && wr.addr == OFS_TAG_0;
   wire wr_tag1  = wr.en && wr.addr == OFS_TAG_1;
   wire wr_tag2  = wr.en && wr.addr == OFS_TAG_2;
   wire wr_ecc   = wr.en && wr.addr == OFS_ECC_CONFIG;
   wire cmd_load = wr_ctrl && wr.data[OTP_LOAD_BIT];
   wire cmd_burn = wr_ctrl && wr.data[OTP_BURN_BIT];
   wire mem_fin  = mem_q != M_IDLE && otp_done;

   // Checksum and correction
   wire [40:0] ecc_data = {cfg_q.ecc_config[ECC_EN_BIT], cfg_q.tag_2,
                           cfg_q.tag_1, cfg_q.tag_0, cfg_q.gain_diag,
                           cfg_q.output_cfg};
   wire [6:0]  chk_calc  = secded_calc(ecc_data); // [R14]
   wire [6:0]  chk_ref   = cfg_q.ecc_config[CHK_W-1:0]; // [R12]
   wire        ecc_on    = cfg_q.ecc_config[ECC_EN_BIT]; // [R13]
   wire [5:0]  syndrome  = chk_calc[5:0] ^ chk_ref[5:0];
   wire        par_bad   = (^ecc_data) ^ (^chk_ref);
   wire        err_one   = ecc_on && par_bad; // [R17]
   wire        err_multi = ecc_on && !par_bad && syndrome != 6'h00; // [R18]
   wire [40:0] fixed     = err_one ? ecc_data ^ flip_mask(syndrome)
                                   : ecc_data; // [R17]
   wire [1:0]  ecc_err   = err_one   ? ECC_ERR_SINGLE :
                           err_multi ? ECC_ERR_MULTI  :
                                       ECC_ERR_NONE; // [R16] [R22]
   wire        en_after  = fixed[40]; // [R15]
   wire [7:0]  status    = {5'h00, ecc_err, en_after};

   // Effective settings come from the corrected image
   wire [7:0]  out_eff  = fixed[7:0];
   wire [7:0]  gain_eff = fixed[15:8];

   // Read view
   wire [1:0]  mem_code = mem_q == M_LOAD ? OTP_ST_LOAD :
                          mem_q == M_BURN ? OTP_ST_BURN : OTP_ST_IDLE;
   wire [7:0]  ctrl_rd  = {1'b0, guard_q, 2'b00,
                           mem_q == M_BURN, mem_q == M_LOAD,
                           mem_code}; // [R1] [R23]

   always_comb begin
      unique case (rd_addr)
         OFS_OTP_CONTROL:   rd_data = ctrl_rd;
         OFS_OUTPUT_CONFIG: rd_data = cfg_q.output_cfg;
         OFS_GAIN_DIAG:     rd_data = cfg_q.gain_diag;
         OFS_TAG_0:         rd_data = cfg_q.tag_0;
         OFS_TAG_1:         rd_data = cfg_q.tag_1;
         OFS_TAG_2:         rd_data = cfg_q.tag_2;
         OFS_ECC_CONFIG:    rd_data = cfg_q.ecc_config;
         OFS_CHECKSUM:      rd_data = {1'b0, chk_calc}; // [R14]
         OFS_ECC_STATUS:    rd_data = status;
         default:           rd_data = REG_RESET;
      endcase
   end

   // Memory controller sequencing
   always_comb begin
      mem_d = mem_q;
      unique case (mem_q)
         M_IDLE: begin
            if (por_load_q || cmd_load) mem_d = M_LOAD; // [R2]
            else if (cmd_burn) mem_d = M_BURN; // [R3]
         end
         M_LOAD: if (otp_done) mem_d = M_IDLE; // [R23]
         M_BURN: if (otp_done) mem_d = M_IDLE; // [R23]
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mem_q      <= M_IDLE;
         por_load_q <= 1'b1;
      end else begin
         mem_q <= mem_d;
         // Held through the power-on load so diag mode can latch from it
         if (mem_q == M_LOAD && otp_done) por_load_q <= 1'b0;
      end
   end

   // Guard-band level only changes while the controller is idle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         guard_q <= 1'b0;
      end else if (wr_ctrl && mem_q == M_IDLE) begin
         guard_q <= wr.data[OTP_GUARD_BIT]; // [R4]
      end
   end

   // Shadow registers; a finished load overrides a host write
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q <= '0; // [R11]
      end else if (mem_q == M_LOAD && otp_done) begin
         cfg_q            <= otp_load_data; // [R2]
         cfg_q.output_cfg <= otp_load_data.output_cfg & OUT_CONFIG_MASK;
         cfg_q.gain_diag  <= otp_load_data.gain_diag & GAIN_CFG_MASK;
      end else begin
         if (wr_out)  cfg_q.output_cfg <= wr.data & OUT_CONFIG_MASK; // [R21]
         if (wr_gain) cfg_q.gain_diag  <= wr.data & GAIN_CFG_MASK; // [R21]
         if (wr_tag0) cfg_q.tag_0      <= wr.data; // [R11]
         if (wr_tag1) cfg_q.tag_1      <= wr.data; // [R11]
         if (wr_tag2) cfg_q.tag_2      <= wr.data; // [R11]
         if (wr_ecc)  cfg_q.ecc_config <= wr.data; // [R12] [R13]
      end
   end

   // Diagnostic mode is latched only by the load that follows reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         diag_q <= 1'b0;
      end else if (mem_q == M_LOAD && otp_done && por_load_q) begin
         diag_q <= otp_load_data.gain_diag[GAIN_DIAG_BIT]; // [R9] [R19]
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         otp_o_q <= 1'b0;
      end else begin
         otp_o_q <= diag_q && ecc_err != ECC_ERR_NONE; // [R19]
      end
   end

   // Note: a load that started from reset tracks por_load_q by holding it
   assign otp_req.load       = mem_q == M_LOAD; // [R2]
   assign otp_req.burn       = mem_q == M_BURN; // [R3]
   assign otp_req.guard_band = guard_q; // [R4]
   assign otp_burn_data      = cfg_q; // [R3] [R11]

   assign common_mode_select       = out_eff[OUT_CM_LEVEL_BIT]; // [R5]
   assign cosine_ref_output_select = out_eff[OUT_COS_REF_BIT]; // [R6]
   assign sine_ref_output_select   = out_eff[OUT_SIN_REF_BIT]; // [R7]
   assign channel_sign_invert      = out_eff[OUT_INVERT_BIT]; // [R8]
   assign gain_code = gain_eff[GAIN_CODE_LSB +: GAIN_CODE_W]; // [R10]
   assign diag_mode_active = diag_q; // [R9]

   // Open drain: only ever pulls low, pull-up gives the ok level
   assign diag_pin_o  = 1'b0;
   assign diag_pin_oe = otp_o_q; // [R19]

endmodule

/* File: hw/uart_frame_seq.sv */
/*
 Four-frame access sequencer: sync, command with address, two data
 frames on two consecutive registers.
 Assumes received and transmitted bytes are already deframed and on
 clk_sys; the transmitter holds tx_ready low while busy.
*/
`timescale 1ns/1ps
module uart_frame_seq
   import sensor_cfg_pkg::*;
(
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   input  wire logic         rx_valid,
   input  wire logic [7:0]   rx_byte,
   input  wire logic         tx_ready,
   input  wire logic [7:0]   rd_data,
   output reg_wr_t           wr,
   output logic [6:0]        rd_addr,
   output logic              tx_valid,
   output logic [7:0]        tx_byte
);

   typedef enum logic [2:0] {
      S_SYNC, S_CMD, S_WDATA1, S_WDATA2, S_REPLY1, S_REPLY2
   } seq_state_t;

   seq_state_t  state_q, state_d;
   logic [6:0]  addr_q;
   logic [7:0]  tx_byte_q;
   reg_wr_t     wr_q;

   wire         sync_ok  = rx_valid && rx_byte == SYNC_BYTE;
   wire         is_read  = rx_byte[RW_BIT];
   wire         tx_taken = tx_valid && tx_ready;
   wire [6:0]   addr_nx  = addr_q + 7'h01;

   assign tx_valid = state_q == S_REPLY1 || state_q == S_REPLY2;
   assign tx_byte  = tx_byte_q;
   assign wr       = wr_q;
   // Command frame carries the address of the first reply byte
   assign rd_addr  = state_q == S_CMD ? rx_byte[6:0] : addr_nx;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         S_SYNC:   if (sync_ok) state_d = S_CMD; // [R20]
         S_CMD:    if (rx_valid) state_d = is_read ? S_REPLY1 : S_WDATA1;
         S_WDATA1: if (rx_valid) state_d = S_WDATA2;
         S_WDATA2: if (rx_valid) state_d = S_SYNC;
         S_REPLY1: if (tx_taken) state_d = S_REPLY2;
         S_REPLY2: if (tx_taken) state_d = S_SYNC;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q   <= S_SYNC;
         addr_q    <= '0;
         tx_byte_q <= REG_RESET;
         wr_q      <= '0;
      end else begin
         state_q <= state_d;
         wr_q.en <= 1'b0;
         if (state_q == S_CMD && rx_valid) begin
            addr_q <= rx_byte[6:0];
            if (is_read) tx_byte_q <= rd_data; // [R20]
         end
         if ((state_q == S_WDATA1 || state_q == S_WDATA2) && rx_valid) begin
            wr_q.en   <= 1'b1;
            wr_q.addr <= state_q == S_WDATA1 ? addr_q : addr_nx; // [R20]
            wr_q.data <= rx_byte;
         end
         if (state_q == S_REPLY1 && tx_taken) tx_byte_q <= rd_data;
      end
   end

endmodule

/* File: inc/sensor_cfg_pkg.sv */
/*
 Constants, field positions and carrier types of the sensor
 configuration register bank.
 Assumes one clock domain and a byte-level receiver/transmitter
 outside that deframes the single-wire UART.
*/
// Notes on behaviour
// [R1] Memory control register bits 0..1 show the memory controller state.
// [R2] Writing one to control bit 2 reloads shadow registers from fuses.
// [R3] Writing one to control bit 3 burns current settings into fuses.
// [R4] Control bit 6 selects tightened guard-band margins for fuse reads.
// [R5] Output config bit 3 picks low (0) or high (1) common-mode level.
// [R6] Output config bit 5: inverted cosine (0) or cosine reference (1).
// [R7] Output config bit 6: inverted sine (0) or sine reference (1).
// [R8] Output config bit 7 inverts the sign of both channels.
// [R9] Gain config bit 0 enables diagnostic mode; default communication mode.
// [R10] Gain config bits 1..5 hold the five-bit sensitivity code.
// [R11] Three writable tracking bytes, reset zero, burnable, no other effect.
// [R12] Error-correction config bits 0..6 hold the host's reference checksum.
// [R13] Error-correction config bit 7 enables checking of customer area.
// [R14] A 7-bit checksum of current settings reads back in checksum reg.
// [R15] Status bit 0 shows the enable bit after error correction.
// [R16] Error code reads zero when bytes are correct or checking is off.
// [R17] A single-bit error is corrected and reported with its own code.
// [R18] Two or more bad bits: no correction, major-error code reported; the code takes three bad bits for a single error.
// [R19] Diagnostic mode after power-on drives shared pin low on error.
// [R20] Access is sync 0x55, rw plus address, then two data frames.
// [R21] Unassigned config bits read zero and writes to them do nothing.
// [R22] Single error uses code 1, multiple error code 2, code 3 unused.
// [R23] State field read-only; load and burn bits self-clear when done.
package sensor_cfg_pkg;

   localparam int unsigned ADDR_W = 7;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned CHK_W  = 7;
   localparam int unsigned ECC_D_W = 41;

   localparam logic [6:0] OFS_OTP_CONTROL   = 7'h03;
   localparam logic [6:0] OFS_OUTPUT_CONFIG = 7'h16;
   localparam logic [6:0] OFS_GAIN_DIAG     = 7'h17;
   localparam logic [6:0] OFS_TAG_0         = 7'h18;
   localparam logic [6:0] OFS_TAG_1         = 7'h19;
   localparam logic [6:0] OFS_TAG_2         = 7'h1a;
   localparam logic [6:0] OFS_ECC_CONFIG    = 7'h1b;
   localparam logic [6:0] OFS_CHECKSUM      = 7'h50;
   localparam logic [6:0] OFS_ECC_STATUS    = 7'h51;

   localparam logic [7:0] REG_RESET = 8'h00;

   localparam int unsigned OTP_LOAD_BIT  = 2;
   localparam int unsigned OTP_BURN_BIT  = 3;
   localparam int unsigned OTP_GUARD_BIT = 6;

   localparam int unsigned OUT_CM_LEVEL_BIT = 3;
   localparam int unsigned OUT_COS_REF_BIT  = 5;
   localparam int unsigned OUT_SIN_REF_BIT  = 6;
   localparam int unsigned OUT_INVERT_BIT   = 7;
   localparam logic [7:0]  OUT_CONFIG_MASK  = 8'he8;

   localparam int unsigned GAIN_DIAG_BIT  = 0;
   localparam int unsigned GAIN_CODE_LSB  = 1;
   localparam int unsigned GAIN_CODE_W    = 5;
   localparam logic [7:0]  GAIN_CFG_MASK  = 8'h3f;

   localparam int unsigned ECC_EN_BIT = 7;

   localparam logic [1:0] OTP_ST_IDLE = 2'h0;
   localparam logic [1:0] OTP_ST_LOAD = 2'h1;
   localparam logic [1:0] OTP_ST_BURN = 2'h2;

   localparam logic [1:0] ECC_ERR_NONE   = 2'h0;
   localparam logic [1:0] ECC_ERR_SINGLE = 2'h1;
   localparam logic [1:0] ECC_ERR_MULTI  = 2'h2;

   localparam logic [7:0] SYNC_BYTE = 8'h55;
   localparam int unsigned RW_BIT   = 7;

   typedef struct packed {
      logic [7:0] ecc_config;
      logic [7:0] tag_2;
      logic [7:0] tag_1;
      logic [7:0] tag_0;
      logic [7:0] gain_diag;
      logic [7:0] output_cfg;
   } cust_cfg_t;

   typedef struct packed {
      logic       en;
      logic [6:0] addr;
      logic [7:0] data;
   } reg_wr_t;

   typedef struct packed {
      logic load;
      logic burn;
      logic guard_band;
   } otp_req_t;

endpackage

/* File: testbench/fuse_array_model.sv */
/*
 Behavioural fuse array answering load and burn requests.
 Assumes requests stand until otp_done; image survives rst_n.
*/
`timescale 1ns/1ps
module fuse_array_model
   import sensor_cfg_pkg::*;
#(
   parameter int unsigned DELAY = 40
)
(
   input  wire logic      clk_sys,
   input  wire logic      rst_n,
   input  wire otp_req_t  otp_req,
   input  wire cust_cfg_t otp_burn_data,
   output cust_cfg_t      otp_load_data,
   output logic           otp_done
);
   cust_cfg_t   image;
   logic [47:0] flip;
   int unsigned cnt;

   initial begin
      image = '0;
      flip = '0;
   end
   // Idle bus shows the inverse so a stray sample is caught
   assign otp_load_data = (otp_req.load && otp_done) ? image ^ flip : ~image;

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 0;
         otp_done <= 1'b0;
      end else begin
         otp_done <= 1'b0;
         if ((otp_req.load || otp_req.burn) && !otp_done) begin
            if (cnt == DELAY) begin
               otp_done <= 1'b1;
               cnt <= 0;
               if (otp_req.burn) begin
                  image <= otp_burn_data;
               end
            end else begin
               cnt <= cnt + 1;
            end
         end
      end
   end
endmodule

/* File: testbench/sensor_config_otp_ecc_regs_chk.sv */
/*
 Port-level checks of the register bank: fuse requests, replies, diag pin.
 Assumes one clock domain; bound to every instance of the bank.
*/
`timescale 1ns/1ps
module sensor_config_otp_ecc_regs_chk
   import sensor_cfg_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire logic       rx_valid,
   input  wire logic       tx_ready,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_byte,
   input  wire otp_req_t   otp_req,
   input  wire logic       otp_done,
   input  wire logic       diag_mode_active,
   input  wire logic       diag_pin_o,
   input  wire logic       diag_pin_oe
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   a_load_at_start: assert property ($rose(rst_n) |-> ##[0:2] otp_req.load)
      else $error("no fuse load after reset");
   a_load_holds: assert property (otp_req.load && !otp_done |=> otp_req.load)
      else $error("load request dropped early");
   a_load_clears: assert property (otp_req.load && otp_done |=> !otp_req.load)
      else $error("load request not cleared");
   a_burn_clears: assert property (otp_req.burn && otp_done |=> !otp_req.burn)
      else $error("burn request not cleared");
   a_one_op: assert property (!(otp_req.load && otp_req.burn))
      else $error("load and burn together");
   a_burn_cause: assert property ($rose(otp_req.burn) |-> $past(rx_valid, 2))
      else $error("burn without written byte");
   a_reply_holds: assert property (tx_valid && !tx_ready |=>
      tx_valid && $stable(tx_byte))
      else $error("reply byte not held");
   a_reply_cause: assert property ($rose(tx_valid) |-> $past(rx_valid))
      else $error("reply without command byte");
   a_diag_latch: assert property ($changed(diag_mode_active) |-> $past(otp_done))
      else $error("diag mode changed outside load");
   a_pin_drive: assert property (diag_pin_oe |-> diag_mode_active && !diag_pin_o)
      else $error("diag pin driven outside diag mode");
endmodule

bind sensor_config_otp_ecc_regs sensor_config_otp_ecc_regs_chk u_chk (
   .clk_sys(clk_sys), .rst_n(rst_n), .rx_valid(rx_valid),
   .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte),
   .otp_req(otp_req), .otp_done(otp_done),
   .diag_mode_active(diag_mode_active), .diag_pin_o(diag_pin_o),
   .diag_pin_oe(diag_pin_oe)
);

/* File: testbench/sensor_config_otp_ecc_regs_tb.sv */
/*
 Self-checking bench of the register bank over its byte link.
 Assumes the fuse array model and the bound port checker.
*/
`timescale 1ns/1ps
module sensor_config_otp_ecc_regs_tb
   import sensor_cfg_pkg::*;
;
   logic        clk_sys, rst_n, rx_valid, tx_ready, tx_valid, otp_done;
   logic [7:0]  rx_byte, tx_byte;
   logic        cm_sel, cos_sel, sin_sel, inv, diag_act, pin_o, pin_oe;
   logic [4:0]  gain;
   otp_req_t    otp_req;
   cust_cfg_t   burn_data, load_data;
   int          n_errors, n_checks, cyc;
   logic [40:0] img;
   logic [6:0]  sum;

   sensor_config_otp_ecc_regs u_sensor_config_otp_ecc_regs (
      .clk_sys(clk_sys), .rst_n(rst_n), .rx_valid(rx_valid),
      .rx_byte(rx_byte), .tx_ready(tx_ready), .tx_valid(tx_valid),
      .tx_byte(tx_byte), .otp_req(otp_req), .otp_burn_data(burn_data),
      .otp_load_data(load_data), .otp_done(otp_done),
      .common_mode_select(cm_sel), .cosine_ref_output_select(cos_sel),
      .sine_ref_output_select(sin_sel), .channel_sign_invert(inv),
      .gain_code(gain), .diag_mode_active(diag_act),
      .diag_pin_o(pin_o), .diag_pin_oe(pin_oe));
   fuse_array_model u_fuse_array_model (
      .clk_sys(clk_sys), .rst_n(rst_n), .otp_req(otp_req),
      .otp_burn_data(burn_data), .otp_load_data(load_data),
      .otp_done(otp_done));

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   function automatic logic [6:0] ecc_of(input logic [40:0] d);
      logic [6:0] c;
      int k;
      c = '0;
      k = 0;
      for (int p = 1; p < 48; p++) begin
         if ((p & (p - 1)) != 0) begin
            for (int j = 0; j < 6; j++) begin
               if (p[j]) c[j] = c[j] ^ d[k];
            end
            k++;
         end
      end
      c[6] = ^d ^ ^c[5:0];
      return c;
   endfunction

   task automatic chk(input string what, input logic [7:0] exp, got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic send(input logic [7:0] b);
      @(posedge clk_sys);
      rx_valid <= 1'b1;
      rx_byte <= b;
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d1, d2);
      send(SYNC_BYTE);
      send({1'b0, a});
      send(d1);
      send(d2);
      @(posedge clk_sys);
      rx_valid <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask

   // Ready held low one cycle so every reply must stand
   task automatic rd_chk(input string what, input logic [6:0] a,
                         input logic [7:0] e1, e2);
      logic [7:0] got [2];
      int i;
      send(SYNC_BYTE);
      send({1'b1, a});
      @(posedge clk_sys);
      rx_valid <= 1'b0;
      for (int n = 0; n < 2; n++) begin
         i = 0;
         do @(negedge clk_sys); while (tx_valid !== 1'b1 && ++i < 50);
         got[n] = tx_byte;
         @(posedge clk_sys);
         tx_ready <= 1'b1;
         @(posedge clk_sys);
         tx_ready <= 1'b0;
      end
      chk(what, e1, got[0]);
      chk(what, e2, got[1]);
   endtask

   task automatic wait_idle;
      int i;
      i = 0;
      do @(negedge clk_sys);
      while ((otp_req.load | otp_req.burn) !== 1'b0 && ++i < 200);
   endtask

   task automatic do_reset;
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      wait_idle();
   endtask

   task automatic t_reset_values;
      for (int a = 'h16; a < 'h1c; a += 2) begin
         rd_chk("reset", 7'(a), REG_RESET, REG_RESET);
      end
      rd_chk("sum status", OFS_CHECKSUM, 8'h00, 8'h00);
      rd_chk("control", OFS_OTP_CONTROL, 8'h00, 8'h00);
      $display("test reset values done");
   endtask

   task automatic t_config;
      logic [7:0] o [2] = '{8'hff, 8'h08};
      logic [7:0] g [2] = '{8'hff, 8'h0a};
      for (int i = 0; i < 2; i++) begin
         wr(OFS_OUTPUT_CONFIG, o[i], g[i]);
         rd_chk("cfg", OFS_OUTPUT_CONFIG, o[i] & 8'he8, g[i] & 8'h3f);
         chk("outs", {4'h0, o[i][3], o[i][5], o[i][6], o[i][7]},
             {4'h0, cm_sel, cos_sel, sin_sel, inv});
         chk("gain", {3'h0, g[i][5:1]}, {3'h0, gain});
         chk("diag", 8'h00, {7'h0, diag_act});
      end
      $display("test config done");
   endtask

   task automatic t_tags_checksum;
      img = {1'b1, 8'h3c, 8'h5a, 8'ha5, 8'h0a, 8'h08};
      sum = ecc_of(img);
      wr(OFS_TAG_0, 8'ha5, 8'h5a);
      wr(OFS_TAG_2, 8'h3c, {1'b1, sum});
      rd_chk("tags", OFS_TAG_0, 8'ha5, 8'h5a);
      rd_chk("tag ecc", OFS_TAG_2, 8'h3c, {1'b1, sum});
      wr(OFS_CHECKSUM, 8'hff, 8'hff);
      rd_chk("sum status", OFS_CHECKSUM, {1'b0, sum}, 8'h01);
      $display("test tags checksum done");
   endtask

   task automatic t_burn;
      logic [47:0] exp_img;
      // Reference checksum sits beside the enable bit in the fuse image
      exp_img = {img[40], sum, img[39:0]};
      wr(7'h02, 8'hff, 8'h08);
      rd_chk("busy", 7'h02, 8'h00, 8'h0a);
      wait_idle();
      rd_chk("idle", OFS_OTP_CONTROL, 8'h00, 8'h00);
      for (int i = 0; i < 6; i++) begin
         chk("fuse", exp_img[i*8 +: 8],
             u_fuse_array_model.image[i*8 +: 8]);
      end
      wr(OFS_OTP_CONTROL, 8'h40, 8'h00);
      chk("guard", 8'h01, {7'h0, otp_req.guard_band});
      rd_chk("guard rd", OFS_OTP_CONTROL, 8'h40, 8'h00);
      wr(OFS_OTP_CONTROL, 8'h00, 8'h00);
      $display("test burn done");
   endtask

   task automatic t_ecc_fault;
      logic [47:0] f [2] = '{48'h8, 48'h10008};
      logic [7:0] st [2] = '{8'h03, 8'h05};
      for (int i = 0; i < 2; i++) begin
         u_fuse_array_model.flip = f[i];
         wr(OFS_OTP_CONTROL, 8'h04, 8'h00);
         wait_idle();
         // Checksum follows the raw, uncorrected shadow image
         rd_chk("raw sum", OFS_CHECKSUM - 7'h1, 8'h00,
                {1'b0, ecc_of(img ^ f[i][40:0])});
         rd_chk("ecc st", OFS_ECC_STATUS, st[i], 8'h00);
         chk("corrected", {7'h0, i == 0}, {7'h0, cm_sel});
      end
      $display("test ecc fault done");
   endtask

   task automatic t_diag;
      img = {1'b1, 24'h0, 8'h01, 8'h00};
      u_fuse_array_model.image = {1'b1, ecc_of(img), 24'h0, 8'h01, 8'h00};
      u_fuse_array_model.flip = 48'h200;
      do_reset();
      repeat (3) @(posedge clk_sys);
      chk("diag", 8'h01, {7'h0, diag_act});
      chk("pin", 8'h02, {6'h0, pin_oe, pin_o});
      chk("gain", 8'h00, {3'h0, gain});
      $display("test diag done");
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         final_report();
      end
   end

   initial begin
      rst_n = 1'b0;
      rx_valid = 1'b0;
      rx_byte = 8'h00;
      tx_ready = 1'b0;
      do_reset();
      t_reset_values();
      t_config();
      t_tags_checksum();
      t_burn();
      t_ecc_fault();
      t_diag();
      final_report();
   end
endmodule
